/* File: design/pdf_pkg.sv */
// Shared constants and types for the port pin function select block
package pdf_pkg;

	// Pin counts and widths
	localparam int PDF_LOW_PINS  = 16;
	localparam int PDF_PINS      = 25;
	localparam int PDF_IRQ_COUNT = 8;
	localparam int PDF_DMA_PIN   = 24;
	localparam int PDF_FIELD_W   = 2;
	localparam int PDF_REG_W     = 16;
	localparam int PDF_ADDR_W    = 4;
	localparam int PDF_DATA_W    = 32;
	localparam int PDF_BE_W      = 4;
	localparam int PDF_SYNC_W    = 2;

	// Pin 24 field inside the upper high-byte register
	localparam int PDF_PIN24_LSB = 0;

	// Register byte offsets
	localparam logic [PDF_ADDR_W-1:0] PDF_OFS_UPPER_HIGH = 4'h0;
	localparam logic [PDF_ADDR_W-1:0] PDF_OFS_UPPER_LOW  = 4'h4;
	localparam logic [PDF_ADDR_W-1:0] PDF_OFS_LOWER      = 4'h8;
	localparam logic [PDF_ADDR_W-1:0] PDF_OFS_STATUS     = 4'hc;

	// Reset values
	localparam logic [PDF_REG_W-1:0]  PDF_REG_RST  = 16'h0000;
	localparam logic [PDF_DATA_W-1:0] PDF_READ_ZERO = 32'h0000_0000;

	// Byte lanes holding the 16-bit registers
	localparam logic [PDF_BE_W-1:0] PDF_BE_LANE0 = 4'h1;
	localparam logic [PDF_BE_W-1:0] PDF_BE_LANE1 = 4'h2;

	// Two-bit function field codes
	localparam logic [PDF_FIELD_W-1:0] PDF_FLD_GPIO = 2'h0;
	localparam logic [PDF_FIELD_W-1:0] PDF_FLD_DATA = 2'h1;
	localparam logic [PDF_FIELD_W-1:0] PDF_FLD_ALT  = 2'h2;
	localparam logic [PDF_FIELD_W-1:0] PDF_FLD_RSVD = 2'h3;

	// Chip operating mode
	typedef enum logic [1:0]
	{
		PDF_MODE_SINGLE  = 2'h0,
		PDF_MODE_ROM_EN  = 2'h1,
		PDF_MODE_ROM_DIS = 2'h2
	} pdf_mode_e;

	// Effective function of one pin
	typedef enum logic [3:0]
	{
		PDF_FN_GPIO = 4'h1,
		PDF_FN_DATA = 4'h2,
		PDF_FN_ALT  = 4'h4,
		PDF_FN_OFF  = 4'h8
	} pdf_fn_e;

endpackage : pdf_pkg

/* File: design/pdf_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module pdf_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	import pdf_pkg::*;

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			stage1   <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule : pdf_sync

/* File: design/pdf_regs.sv */
// Avalon-MM slave holding the three function select registers
`timescale 1ns/10ps
module pdf_regs (
	// Clock and power-on reset
	input  wire logic                              ref_clk,
	input  wire logic                              sys_rst,
	// Avalon-MM slave
	input  wire logic [pdf_pkg::PDF_ADDR_W-1:0]    avs_address,
	input  wire logic                              avs_read,
	input  wire logic                              avs_write,
	input  wire logic [pdf_pkg::PDF_DATA_W-1:0]    avs_writedata,
	input  wire logic [pdf_pkg::PDF_BE_W-1:0]      avs_byteenable,
	output logic      [pdf_pkg::PDF_DATA_W-1:0]    avs_readdata,
	output logic                                   avs_waitrequest,
	// Register contents and status
	output logic      [pdf_pkg::PDF_REG_W-1:0]     upper_high,
	output logic      [pdf_pkg::PDF_REG_W-1:0]     upper_low,
	output logic      [pdf_pkg::PDF_REG_W-1:0]     lower,
	input  wire logic [pdf_pkg::PDF_PINS-1:0]      status_in
);
	import pdf_pkg::*;

	logic ack;

	function automatic logic [PDF_REG_W-1:0] merge(input logic [PDF_REG_W-1:0] old,
		input logic [PDF_DATA_W-1:0] wd, input logic [PDF_BE_W-1:0] be);
		logic [PDF_REG_W-1:0] res;
		res = old;
		if ((be & PDF_BE_LANE0) != '0)
			res[7:0] = wd[7:0];
		if ((be & PDF_BE_LANE1) != '0)
			res[15:8] = wd[15:8];
		return res;
	endfunction : merge

	// One wait cycle: request seen, then answered
	assign avs_waitrequest = (avs_read | avs_write) & ~ack;

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			ack <= 1'b0;
		else
			ack <= (avs_read | avs_write) & ~ack;
	end

	// Only power-on reset clears these; other resets never reach here
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			upper_high <= PDF_REG_RST;
			upper_low  <= PDF_REG_RST;
			lower      <= PDF_REG_RST;
		end
		else if (avs_write & ack)
		begin
			if (avs_address == PDF_OFS_UPPER_HIGH)
				upper_high <= merge(upper_high, avs_writedata, avs_byteenable);
			else if (avs_address == PDF_OFS_UPPER_LOW)
				upper_low <= merge(upper_low, avs_writedata, avs_byteenable);
			else if (avs_address == PDF_OFS_LOWER)
				lower <= merge(lower, avs_writedata, avs_byteenable);
		end
	end

	// Read data loaded one edge early so it stands when waitrequest drops
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			avs_readdata <= PDF_READ_ZERO;
		else if (avs_read & ~ack)
		begin
			if (avs_address == PDF_OFS_UPPER_HIGH)
				avs_readdata <= {{(PDF_DATA_W-PDF_REG_W){1'b0}}, upper_high};
			else if (avs_address == PDF_OFS_UPPER_LOW)
				avs_readdata <= {{(PDF_DATA_W-PDF_REG_W){1'b0}}, upper_low};
			else if (avs_address == PDF_OFS_LOWER)
				avs_readdata <= {{(PDF_DATA_W-PDF_REG_W){1'b0}}, lower};
			else if (avs_address == PDF_OFS_STATUS)
				avs_readdata <= {{(PDF_DATA_W-PDF_PINS){1'b0}}, status_in};
			else
				avs_readdata <= PDF_READ_ZERO;
		end
	end

endmodule : pdf_regs

/* File: design/pdf_top.sv */
// Pin function multiplexer for port pins 0 to 24
// Behaviour
// - Pin 24 field 01 selects data bit 24, 10 selects the DMA channel 0 request, 11 is reserved; here 10 gives general I/O if single-chip, data if wide_bus.
// - The upper low-byte register holds a 2-bit field per pin, pin 23 at bits 15:14 down to pin 16 at 1:0.
// - An upper field of 00 selects general I/O and is the reset value.
// - An upper field of 01 routes the pin to the data-bus bit of the same number.
// - An upper field of 10 routes the pin to interrupt request pin-16; 11 is reserved.
// - In single-chip mode a data-bus selection has no effect and the pin stays general I/O.
// - With ROM disabled and a 32-bit area 0, an upper pin set to general I/O acts as its data bit.
// - The lower register is 16-bit read/write with bit n controlling lower pin n.
// - A lower bit of 0 selects general I/O (reset value) and 1 selects the data bit.
// - In ROM-disabled mode the lower pins are data pins and the lower register is ignored.
// - In ROM-enabled mode each lower pin is data or general I/O as its bit selects.
// - In single-chip mode the lower pins are general I/O and the lower register is ignored.
// - The lower register clears only on power-on reset and otherwise keeps its contents.
// - Both upper registers clear only on power-on reset and otherwise keep their contents.
// - Upper settings drive pins only on the largest package; registers stay accessible anyway.
//
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module pdf_top (
	// Clock and power-on reset
	input  wire logic                              ref_clk,
	input  wire logic                              sys_rst,
	// Avalon-MM slave
	input  wire logic [pdf_pkg::PDF_ADDR_W-1:0]    avs_address,
	input  wire logic                              avs_read,
	input  wire logic                              avs_write,
	input  wire logic [pdf_pkg::PDF_DATA_W-1:0]    avs_writedata,
	input  wire logic [pdf_pkg::PDF_BE_W-1:0]      avs_byteenable,
	output logic      [pdf_pkg::PDF_DATA_W-1:0]    avs_readdata,
	output logic                                   avs_waitrequest,
	// Chip configuration
	input  wire pdf_pkg::pdf_mode_e                op_mode,
	input  wire logic                              cs0_area_32bit,
	input  wire logic                              pkg_largest,
	// Pins
	input  wire logic [pdf_pkg::PDF_PINS-1:0]      pin_in,
	output logic      [pdf_pkg::PDF_PINS-1:0]      pin_out,
	output logic      [pdf_pkg::PDF_PINS-1:0]      pin_oe,
	// General-purpose port logic
	input  wire logic [pdf_pkg::PDF_PINS-1:0]      gpio_out,
	input  wire logic [pdf_pkg::PDF_PINS-1:0]      gpio_dir,
	output logic      [pdf_pkg::PDF_PINS-1:0]      gpio_in,
	// External data bus
	input  wire logic [pdf_pkg::PDF_PINS-1:0]      bus_data_out,
	input  wire logic [pdf_pkg::PDF_PINS-1:0]      bus_data_oe,
	output logic      [pdf_pkg::PDF_PINS-1:0]      bus_data_in,
	// Request inputs toward interrupt and DMA controllers
	output logic      [pdf_pkg::PDF_IRQ_COUNT-1:0] ext_irq_req_n,
	output logic                                   dma_req0_n
);
	import pdf_pkg::*;

	logic [PDF_REG_W-1:0] upper_high;
	logic [PDF_REG_W-1:0] upper_low;
	logic [PDF_REG_W-1:0] lower;
	logic [PDF_PINS-1:0]  pin_sync;
	logic [PDF_PINS-1:0]  data_mask;
	pdf_fn_e              fn [PDF_PINS];
	logic                 single_chip;
	logic                 rom_en;
	logic                 rom_dis;
	logic                 wide_bus;

	pdf_regs u_regs (
		.ref_clk         (ref_clk),
		.sys_rst         (sys_rst),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_byteenable  (avs_byteenable),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.upper_high      (upper_high),
		.upper_low       (upper_low),
		.lower           (lower),
		.status_in       (data_mask)
	);

	pdf_sync #(
		.WIDTH (PDF_PINS)
	) u_pin_sync (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.async_in (pin_in),
		.sync_out (pin_sync)
	);

	// Unused mode code 3 falls back to single-chip, the safest pin set
	assign single_chip = ~(rom_en | rom_dis);
	assign rom_en      = (op_mode == PDF_MODE_ROM_EN);
	assign rom_dis     = (op_mode == PDF_MODE_ROM_DIS);
	// Upper general I/O turns into data only for a ROM-less 32-bit area 0
	assign wide_bus    = rom_dis & cs0_area_32bit;

	genvar i;
	generate
		for (i = 0; i < PDF_PINS; i++)
		begin : g_pin
			if (i < PDF_LOW_PINS)
			begin : g_low
				always_comb
				begin
					if (rom_dis)
						fn[i] = PDF_FN_DATA;
					else if (rom_en)
						fn[i] = lower[i] ? PDF_FN_DATA : PDF_FN_GPIO;
					else
						fn[i] = PDF_FN_GPIO;
				end
			end
			else
			begin : g_up
				logic [PDF_FIELD_W-1:0] field;
				// Pin 24 lives in the other upper register
				if (i == PDF_DMA_PIN)
				begin : g_f24
					assign field = upper_high[PDF_PIN24_LSB +: PDF_FIELD_W];
				end
				else
				begin : g_fn
					assign field = upper_low[PDF_FIELD_W*(i-PDF_LOW_PINS) +: PDF_FIELD_W];
				end
				always_comb
				begin
					if (!pkg_largest)
						fn[i] = PDF_FN_OFF;
					else if (field == PDF_FLD_DATA)
						fn[i] = single_chip ? PDF_FN_GPIO : PDF_FN_DATA;
					else if (field == PDF_FLD_ALT)
					begin
						// DMA request falls back like the data options do
						if (i == PDF_DMA_PIN && single_chip)
							fn[i] = PDF_FN_GPIO;
						else if (i == PDF_DMA_PIN && wide_bus)
							fn[i] = PDF_FN_DATA;
						else
							fn[i] = PDF_FN_ALT;
					end
					else if (field == PDF_FLD_RSVD)
						fn[i] = PDF_FN_GPIO; // Reserved code parks the pin safely
					else
						fn[i] = wide_bus ? PDF_FN_DATA : PDF_FN_GPIO;
				end
			end

			assign data_mask[i] = (fn[i] == PDF_FN_DATA);

			// Pin drive from the selected source, off for unrouted functions
			always_ff @(posedge ref_clk or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					pin_out[i] <= 1'b0;
					pin_oe[i]  <= 1'b0;
				end
				else if (fn[i] == PDF_FN_GPIO)
				begin
					pin_out[i] <= gpio_out[i];
					pin_oe[i]  <= gpio_dir[i];
				end
				else if (fn[i] == PDF_FN_DATA)
				begin
					pin_out[i] <= bus_data_out[i];
					pin_oe[i]  <= bus_data_oe[i];
				end
				else
				begin
					pin_out[i] <= 1'b0;
					pin_oe[i]  <= 1'b0;
				end
			end

			// Returned levels reach only the function that owns the pin
			always_ff @(posedge ref_clk or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					gpio_in[i]     <= 1'b0;
					bus_data_in[i] <= 1'b0;
				end
				else
				begin
					gpio_in[i]     <= (fn[i] == PDF_FN_GPIO) & pin_sync[i];
					bus_data_in[i] <= (fn[i] == PDF_FN_DATA) & pin_sync[i];
				end
			end
		end

		// Requests are active low; an unselected source reads idle high
		for (i = 0; i < PDF_IRQ_COUNT; i++)
		begin : g_irq
			always_ff @(posedge ref_clk or posedge sys_rst)
			begin
				if (sys_rst)
					ext_irq_req_n[i] <= 1'b1;
				else if (fn[i+PDF_LOW_PINS] == PDF_FN_ALT)
					ext_irq_req_n[i] <= pin_sync[i+PDF_LOW_PINS];
				else
					ext_irq_req_n[i] <= 1'b1;
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			dma_req0_n <= 1'b1;
		else if (fn[PDF_DMA_PIN] == PDF_FN_ALT)
			dma_req0_n <= pin_sync[PDF_DMA_PIN];
		else
			dma_req0_n <= 1'b1;
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	property p_dma_req;
		pkg_largest && !single_chip && !wide_bus && upper_high[1:0] == PDF_FLD_ALT
			|=> dma_req0_n == $past(pin_sync[PDF_DMA_PIN]);
	endproperty
	a_dma_req: assert property (p_dma_req)
		else $error("pin 24 DMA request not routed");

	property p_field_pos;
		pkg_largest && !single_chip && upper_low[15:14] == PDF_FLD_DATA
			|-> fn[23] == PDF_FN_DATA && fn[22] != PDF_FN_OFF;
	endproperty
	a_field_pos: assert property (p_field_pos)
		else $error("pin 23 field not at bits 15:14");

	property p_gpio_code;
		pkg_largest && !wide_bus && upper_low[1:0] == PDF_FLD_GPIO |-> fn[16] == PDF_FN_GPIO;
	endproperty
	a_gpio_code: assert property (p_gpio_code)
		else $error("upper code 00 not general I/O");

	property p_data_route;
		pkg_largest && !single_chip && upper_low[11:10] == PDF_FLD_DATA
			##1 pkg_largest && !single_chip && upper_low[11:10] == PDF_FLD_DATA
			|=> bus_data_in[21] == $past(pin_sync[21]) && gpio_in[21] == 1'b0;
	endproperty
	a_data_route: assert property (p_data_route)
		else $error("pin 21 data bit not routed");

	property p_irq_route;
		pkg_largest && upper_low[15:14] == PDF_FLD_ALT |=> ext_irq_req_n[7] == $past(pin_sync[23]);
	endproperty
	a_irq_route: assert property (p_irq_route)
		else $error("pin 23 not routed to request 7");

	property p_single_no_data;
		single_chip |-> data_mask == '0;
	endproperty
	a_single_no_data: assert property (p_single_no_data)
		else $error("data function active in single-chip mode");

	property p_wide_gpio;
		pkg_largest && wide_bus && upper_low[5:4] == PDF_FLD_GPIO |-> data_mask[18];
	endproperty
	a_wide_gpio: assert property (p_wide_gpio)
		else $error("32-bit area 0 did not force data bit");

	property p_lower_write;
		avs_write && !avs_waitrequest && avs_address == PDF_OFS_LOWER && avs_byteenable == 4'h3
			|=> lower == $past(avs_writedata[15:0]);
	endproperty
	a_lower_write: assert property (p_lower_write)
		else $error("lower register write lost");

	property p_lower_bit;
		rom_en |-> fn[5] == (lower[5] ? PDF_FN_DATA : PDF_FN_GPIO);
	endproperty
	a_lower_bit: assert property (p_lower_bit)
		else $error("lower bit 5 decode wrong");

	property p_romdis_lower;
		rom_dis |-> data_mask[PDF_LOW_PINS-1:0] == '1;
	endproperty
	a_romdis_lower: assert property (p_romdis_lower)
		else $error("ROM-disabled mode lower pins not data");

	property p_romen_drive;
		!sys_rst && rom_en && lower[1] && bus_data_oe[1]
			|=> pin_oe[1] && pin_out[1] == $past(bus_data_out[1]);
	endproperty
	a_romen_drive: assert property (p_romen_drive)
		else $error("ROM-enabled data pin not driven");

	property p_single_lower;
		single_chip && lower[0] |-> fn[0] == PDF_FN_GPIO;
	endproperty
	a_single_lower: assert property (p_single_lower)
		else $error("single-chip lower pin not general I/O");

	property p_lower_keep;
		!(avs_write && !avs_waitrequest) |=> $stable(lower);
	endproperty
	a_lower_keep: assert property (p_lower_keep)
		else $error("lower register changed without a write");

	property p_upper_keep;
		!(avs_write && !avs_waitrequest) |=> $stable(upper_low) && $stable(upper_high);
	endproperty
	a_upper_keep: assert property (p_upper_keep)
		else $error("upper register changed without a write");

	property p_pkg_off;
		(!pkg_largest) [*2] |-> pin_oe[PDF_PINS-1:PDF_LOW_PINS] == '0 && ext_irq_req_n == '1;
	endproperty
	a_pkg_off: assert property (p_pkg_off)
		else $error("upper pins driven on small package");

	property p_gpio_bypass;
		// Reset edge itself excluded: the flops load zero there, not the port logic
		!sys_rst && fn[7] == PDF_FN_GPIO
			|=> pin_out[7] == $past(gpio_out[7]) && pin_oe[7] == $past(gpio_dir[7]);
	endproperty
	a_gpio_bypass: assert property (p_gpio_bypass)
		else $error("general I/O pin not following port logic");

	property p_gpio_in_route;
		!sys_rst && fn[2] == PDF_FN_GPIO
			|=> gpio_in[2] == $past(pin_sync[2]) && bus_data_in[2] == 1'b0;
	endproperty
	a_gpio_in_route: assert property (p_gpio_in_route)
		else $error("general I/O input level not forwarded");

	property p_rsvd_gpio;
		pkg_largest && upper_low[15:14] == PDF_FLD_RSVD |-> fn[23] == PDF_FN_GPIO;
	endproperty
	a_rsvd_gpio: assert property (p_rsvd_gpio)
		else $error("reserved code did not park pin 23");

	property p_dma_single;
		pkg_largest && single_chip && upper_high[1:0] == PDF_FLD_ALT
			|-> fn[PDF_DMA_PIN] == PDF_FN_GPIO;
	endproperty
	a_dma_single: assert property (p_dma_single)
		else $error("pin 24 request active in single-chip mode");

	property p_small_no_data;
		!pkg_largest |-> data_mask[PDF_PINS-1:PDF_LOW_PINS] == '0;
	endproperty
	a_small_no_data: assert property (p_small_no_data)
		else $error("upper pin routed on small package");

endmodule : pdf_top

/* File: bench/port_d_pin_function_select_bench.sv */
// Self-checking bench for the port pin function multiplexer
`timescale 1ns/10ps
module port_d_pin_function_select_bench;
	import pdf_pkg::*;

	logic                      ref_clk = 1'b0;
	logic                      sys_rst = 1'b1;
	logic [PDF_ADDR_W-1:0]     avs_address = 4'h0;
	logic                      avs_read = 1'b0, avs_write = 1'b0;
	logic [PDF_DATA_W-1:0]     avs_writedata = 32'h0000_0000;
	logic [PDF_BE_W-1:0]       avs_byteenable = 4'h0;
	logic [PDF_DATA_W-1:0]     avs_readdata;
	logic                      avs_waitrequest;
	pdf_mode_e                 op_mode = PDF_MODE_SINGLE;
	logic                      cs0_area_32bit = 1'b0, pkg_largest = 1'b1;
	logic [PDF_PINS-1:0]       pin_in = '0, gpio_out = '0, gpio_dir = '0;
	logic [PDF_PINS-1:0]       bus_data_out = '0, bus_data_oe = '0;
	logic [PDF_PINS-1:0]       pin_out, pin_oe, gpio_in, bus_data_in;
	logic [PDF_IRQ_COUNT-1:0]  ext_irq_req_n;
	logic                      dma_req0_n;
	int                        err_total = 0;
	int                        checked = 0;
	logic [15:0]               r_uh = 16'h0000, r_ul = 16'h0000, r_lo = 16'h0000;

	always #2.5 ref_clk = ~ref_clk;

	pdf_top u_dut (
		.ref_clk(ref_clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.op_mode(op_mode), .cs0_area_32bit(cs0_area_32bit), .pkg_largest(pkg_largest),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.gpio_out(gpio_out), .gpio_dir(gpio_dir), .gpio_in(gpio_in),
		.bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .bus_data_in(bus_data_in),
		.ext_irq_req_n(ext_irq_req_n), .dma_req0_n(dma_req0_n)
	);

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	// Holds the request until waitrequest is seen low at a rising edge
	task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] rd);
		int n;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= ~wr;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		chk("waitrequest", 32'h0000_0000, 32'(avs_waitrequest));
	endtask : bus_xfer

	task automatic wreg(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] rd;
		bus_xfer(1'b1, a, d, be, rd);
	endtask : wreg

	task automatic rchk(input string what, input logic [3:0] a, input logic [15:0] e);
		logic [31:0] rd;
		bus_xfer(1'b0, a, 32'h0000_0000, 4'hf, rd);
		chk(what, 32'(e), 32'(rd[15:0]));
	endtask : rchk

	// Expected function of pin i from the current registers and strap inputs
	function automatic pdf_fn_e exp_fn(input int i);
		logic [1:0] m;
		logic [1:0] c;
		logic sc, rd;
		m = op_mode;
		sc = (m == 2'h0) || (m == 2'h3);
		rd = (m == 2'h2);
		if (i < PDF_LOW_PINS)
			return (!sc && (rd || r_lo[i])) ? PDF_FN_DATA : PDF_FN_GPIO;
		if (!pkg_largest)
			return PDF_FN_OFF;
		c = (i == PDF_DMA_PIN) ? r_uh[1:0] : r_ul[2*(i-16) +: 2];
		if (c == PDF_FLD_ALT && i == PDF_DMA_PIN && (sc || (rd && cs0_area_32bit)))
			return sc ? PDF_FN_GPIO : PDF_FN_DATA;
		if (c == PDF_FLD_ALT)
			return PDF_FN_ALT;
		if (c == PDF_FLD_DATA)
			return sc ? PDF_FN_GPIO : PDF_FN_DATA;
		if (c == PDF_FLD_GPIO && rd && cs0_area_32bit)
			return PDF_FN_DATA;
		return PDF_FN_GPIO;
	endfunction : exp_fn

	// Drives one pin pattern and compares every pin-side output
	task automatic run_pins(input logic [24:0] p);
		logic [24:0] e_oe, e_out, e_gi, e_bi, e_dm;
		logic [7:0] e_irq;
		logic [31:0] rd;
		logic gv, dv;
		pdf_fn_e f;
		@(posedge ref_clk);
		pin_in <= p;
		gpio_out <= ~p;
		gpio_dir <= p ^ 25'h00ff0ff;
		bus_data_out <= p ^ 25'h1555555;
		bus_data_oe <= p ^ 25'h00f0f0f;
		repeat (4) @(posedge ref_clk);
		#1;
		e_irq = 8'hff;
		for (int i = 0; i < PDF_PINS; i++)
		begin
			f = exp_fn(i);
			gv = (f == PDF_FN_GPIO);
			dv = (f == PDF_FN_DATA);
			e_dm[i] = dv;
			e_oe[i] = gv ? gpio_dir[i] : (dv ? bus_data_oe[i] : 1'b0);
			e_out[i] = gv ? gpio_out[i] : (dv ? bus_data_out[i] : 1'b0);
			e_gi[i] = gv & p[i];
			e_bi[i] = dv & p[i];
			if (i >= 16 && i < 24 && f == PDF_FN_ALT)
				e_irq[i-16] = p[i];
		end
		chk("pin_oe", 32'(e_oe), 32'(pin_oe));
		chk("pin_out", 32'(e_out), 32'(pin_out));
		chk("gpio_in", 32'(e_gi), 32'(gpio_in));
		chk("bus_data_in", 32'(e_bi), 32'(bus_data_in));
		chk("ext_irq_req_n", 32'(e_irq), 32'(ext_irq_req_n));
		chk("dma_req0_n", 32'(exp_fn(24) == PDF_FN_ALT ? p[24] : 1'b1), 32'(dma_req0_n));
		bus_xfer(1'b0, PDF_OFS_STATUS, 32'h0000_0000, 4'hf, rd);
		chk("status", 32'(e_dm), 32'(rd[24:0]));
	endtask : run_pins

	task automatic t_reset_values;
		rchk("upper_high", PDF_OFS_UPPER_HIGH, 16'h0000);
		rchk("upper_low", PDF_OFS_UPPER_LOW, 16'h0000);
		rchk("lower", PDF_OFS_LOWER, 16'h0000);
		rchk("unmapped", 4'h2, 16'h0000);
		$display("test reset_values done");
	endtask : t_reset_values

	// Small package first: registers must stay writable without pins
	task automatic t_reg_access;
		pkg_largest <= 1'b0;
		wreg(PDF_OFS_LOWER, 32'hffff_11c3, 4'hd);
		rchk("lower lane0", PDF_OFS_LOWER, 16'h00c3);
		wreg(PDF_OFS_LOWER, 32'h0000_a522, 4'h2);
		rchk("lower lane1", PDF_OFS_LOWER, 16'ha5c3);
		wreg(PDF_OFS_LOWER, 32'h0000_a5c3, 4'h3);
		wreg(PDF_OFS_UPPER_LOW, 32'h0000_e4c9, 4'h3);
		wreg(4'h2, 32'h0000_ffff, 4'hf);
		rchk("upper_low", PDF_OFS_UPPER_LOW, 16'he4c9);
		wreg(PDF_OFS_UPPER_HIGH, 32'h0000_5a02, 4'h3);
		rchk("upper_high", PDF_OFS_UPPER_HIGH, 16'h5a02);
		r_lo = 16'ha5c3;
		r_ul = 16'he4c9;
		$display("test reg_access done");
	endtask : t_reg_access

	// Every pin-24 code against every mode, bus width and package
	task automatic t_modes;
		for (int c = 0; c < 4; c++)
		begin
			r_uh = 16'h5a00 | 16'(c);
			wreg(PDF_OFS_UPPER_HIGH, 32'(r_uh), 4'h3);
			// Rotating the fields walks every code through pins 18, 19, 22 and 23
			if (c > 0)
				r_ul = {r_ul[13:0], r_ul[15:14]};
			wreg(PDF_OFS_UPPER_LOW, 32'(r_ul), 4'h3);
			for (int k = 0; k < 16; k++)
			begin
				@(posedge ref_clk);
				op_mode <= pdf_mode_e'(k[1:0]);
				cs0_area_32bit <= k[2];
				pkg_largest <= k[3];
				run_pins(25'h1a5c3e1);
				run_pins(25'h05a3c1e);
			end
		end
		rchk("lower kept", PDF_OFS_LOWER, 16'ha5c3);
		$display("test modes done");
	endtask : t_modes

	task automatic t_power_on_reset;
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		chk("pin_oe in reset", 32'h0000_0000, 32'(pin_oe));
		chk("irq in reset", 32'h0000_00ff, 32'(ext_irq_req_n));
		@(posedge ref_clk);
		sys_rst <= 1'b0;
		rchk("upper_high", PDF_OFS_UPPER_HIGH, 16'h0000);
		rchk("upper_low", PDF_OFS_UPPER_LOW, 16'h0000);
		rchk("lower", PDF_OFS_LOWER, 16'h0000);
		$display("test power_on_reset done");
	endtask : t_power_on_reset

	// Roughly twenty-five times the expected length of the run
	initial
	begin
		repeat (30000) @(posedge ref_clk);
		err_total++;
		$display("CHECK FAILED watchdog expected end seen timeout");
		final_report();
	end

	initial
	begin
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_reset_values();
		t_reg_access();
		t_modes();
		t_power_on_reset();
		final_report();
	end

endmodule : port_d_pin_function_select_bench
